// ---- verilog/scp_pkg.sv ----
// Shared constants, carrier structs and state types of the serial command port
package scp_pkg;
  // Register selection and command byte layout
  localparam int CMD_W = 8;
  localparam int DATA_W = 24;
  localparam int SHIFT_W = 32;
  localparam int RW_BIT = 6;
  localparam int RS_HI = 5;
  localparam int RS_LO = 3;
  localparam int CREAD_BIT = 2;
  localparam logic [2:0] RS_COMM = 3'h0;
  localparam logic [2:0] RS_MODE = 3'h1;
  localparam logic [2:0] RS_CONF = 3'h2;
  localparam logic [2:0] RS_DATA = 3'h3;
  localparam logic [2:0] RS_ID = 3'h4;
  localparam logic [7:0] CMD_CREAD_ENTER = 8'h5c;
  localparam logic [7:0] CMD_CREAD_EXIT = 8'h58;
  // Mode register fields
  localparam int MD_HI = 23;
  localparam int MD_LO = 21;
  localparam int STA_BIT = 20;
  localparam logic [2:0] MD_CONT = 3'h0;
  localparam logic [2:0] MD_SINGLE = 3'h1;
  localparam logic [2:0] MD_PDOWN = 3'h2;
  localparam logic [23:0] MODE_RESET = 24'h000000;
  // Configuration register fields
  localparam int EN_HI = 15;
  localparam int EN_LO = 8;
  localparam logic [23:0] CONF_RESET = 24'h000100;
  // Status byte layout
  localparam int STAT_RDY_BIT = 7;
  localparam int STAT_CH_W = 4;
  // Identity byte, value is arbitrary
  localparam logic [7:0] ID_VALUE = 8'h5a;
  // Transfer lengths in serial clocks
  localparam int CNT_W = 6;
  localparam logic [5:0] LEN_BYTE = 6'h08;
  localparam logic [5:0] LEN_WORD = 6'h18;
  localparam logic [5:0] LEN_WORD_STA = 6'h20;
  localparam logic [5:0] ONES_RESET = 6'h28;
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int OSC_START_NS = 1000000;
  localparam int OSC_START_CYC = (OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OSC_CNT_W = 20;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic din;
  } scp_pins_s;

  typedef struct packed {
    logic valid;
    logic [23:0] word;
  } scp_result_s;

  typedef enum {ST_CMD, ST_WRITE, ST_READ} scp_ser_e;
  typedef enum {SQ_OFF, SQ_WAKE, SQ_START, SQ_WAIT} scp_seq_e;
endpackage

// ---- verilog/scp_sync.sv ----
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module scp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge mclk) begin
    if (srst) begin
      meta_reg <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// ---- verilog/scp_port.sv ----
// Serial command port with conversion sequencing and continuous read
`timescale 1ns/1ps
// Overview of operation
// - First byte after reset is command
// - Command picks read/write and target register
// - Data in on din, out on shared line
// - Ready low on new word, high after read
// - Ready high before data register update
// - Chip select gates device, may stay low
// - Repeat reads allowed except in continuous read
// - MSB presented on chip select assertion
// - Forty ones on din reset everything
// - Single mode: one conversion per enabled channel, then power down
// - Oscillator start delay from power down
// - Single mode ready stays high after read
// - Single mode converts each enabled channel once
// - Append status byte, channel in low bits
// - Continuous conversion at power up, ready low
// - Result dropped while data register read, unless in continuous read
// - Continuous mode loops enabled channels
// - Command enters continuous read mode
// - Unread word replaced by newer result
// - Exit command watched on din
// - Eight channel enable bits select sequence
module scp_port #(
  parameter int OSC_START_CYCLES = scp_pkg::OSC_START_CYC
) (
  input wire logic mclk,
  input wire logic srst,
  input scp_pkg::scp_pins_s pins,
  output logic dout_rdy,
  output logic dout_rdy_oe,
  input scp_pkg::scp_result_s conv_result,
  output logic conv_start,
  output logic [2:0] conv_channel,
  output logic conv_power_up,
  output logic cread_active
);
  import scp_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection

  logic [2:0] pins_sync;
  logic cs_n_s;
  logic sclk_s;
  logic din_s;
  logic sclk_d_reg;
  logic cs_n_d_reg;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic selected;

  scp_sync #(.W(3), .RST_VAL(3'h6)) u_sync (
    .mclk(mclk),
    .srst(srst),
    .d({pins.cs_n, pins.sclk, pins.din}),
    .q(pins_sync)
  );

  assign cs_n_s = pins_sync[2];
  assign sclk_s = pins_sync[1];
  assign din_s = pins_sync[0];
  assign selected = ~cs_n_s;
  assign sclk_rise = selected & sclk_s & ~sclk_d_reg;
  assign sclk_fall = selected & ~sclk_s & sclk_d_reg;
  assign cs_fall = ~cs_n_s & cs_n_d_reg;

  always_ff @(posedge mclk) begin
    if (srst) begin
      sclk_d_reg <= 1'b1;
      cs_n_d_reg <= 1'b1;
    end else begin
      sclk_d_reg <= sclk_s;
      cs_n_d_reg <= cs_n_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interface reset by a run of ones

  logic [5:0] ones_cnt_reg;
  logic ones_rst_reg;
  logic rst;

  assign rst = srst | ones_rst_reg;

  always_ff @(posedge mclk) begin
    if (srst) begin
      ones_cnt_reg <= '0;
      ones_rst_reg <= 1'b0;
    end else begin
      ones_rst_reg <= sclk_rise & din_s & (ones_cnt_reg == ONES_RESET - 6'h01);
      if (ones_rst_reg) begin
        ones_cnt_reg <= '0;
      end else if (sclk_rise) begin
        ones_cnt_reg <= din_s ? ones_cnt_reg + 6'h01 : 6'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared state and decode

  scp_ser_e ser_reg;
  scp_seq_e seq_reg;
  logic [5:0] bit_cnt_reg;
  logic [5:0] len_reg;
  logic [23:0] sh_in_reg;
  logic [31:0] sh_out_reg;
  logic out_bit_reg;
  logic pres_reg;
  logic [2:0] rs_reg;
  logic cread_reg;
  logic [23:0] mode_reg;
  logic [23:0] conf_reg;
  logic [23:0] data_reg;
  logic [3:0] data_ch_reg;
  logic rdy_n_reg;
  logic upd_pend_reg;
  logic [23:0] pend_word_reg;
  logic [3:0] pend_ch_reg;
  logic [2:0] cur_ch_reg;
  logic [OSC_CNT_W-1:0] osc_cnt_reg;
  logic dout_reg;
  logic oe_reg;

  logic [7:0] cmd_byte;
  logic [23:0] wr_word;
  logic last_bit;
  logic cmd_done;
  logic read_done;
  logic write_done;
  logic sta_en;
  logic [7:0] status_byte;
  logic [7:0] chan_en;
  logic [2:0] md;
  logic data_busy;
  logic take_result;
  logic cread_start;
  logic [31:0] cread_word;
  logic [31:0] reg_word;
  logic [5:0] rd_len;
  logic mode_wr;
  logic [2:0] next_ch;
  logic [2:0] first_ch;
  logic seq_wrap;
  logic [2:0] wr_md;

  function automatic logic [2:0] next_enabled(input logic [7:0] en, input logic [2:0] cur);
    logic [2:0] r;
    logic found;
    logic [2:0] c;
    r = cur;
    found = 1'b0;
    for (int i = 1; i <= 8; i++) begin
      c = cur + i[2:0];
      if (!found && en[c]) begin
        r = c;
        found = 1'b1;
      end
    end
    return r;
  endfunction

  assign cmd_byte = {sh_in_reg[6:0], din_s};
  assign wr_word = {sh_in_reg[22:0], din_s};
  assign last_bit = sclk_rise & (bit_cnt_reg == len_reg - 6'h01);
  assign cmd_done = (ser_reg == ST_CMD) & sclk_rise & (bit_cnt_reg == LEN_BYTE - 6'h01);
  assign read_done = (ser_reg == ST_READ) & last_bit;
  assign write_done = (ser_reg == ST_WRITE) & last_bit;
  assign sta_en = mode_reg[STA_BIT];
  assign md = mode_reg[MD_HI:MD_LO];
  assign chan_en = conf_reg[EN_HI:EN_LO];
  assign status_byte = {rdy_n_reg, 3'h0, data_ch_reg};
  assign rd_len = (rs_reg == RS_DATA) ? (sta_en ? LEN_WORD_STA : LEN_WORD) : rd_len_sel(rs_reg);
  assign cread_word = sta_en ? {data_reg, status_byte} : {data_reg, 8'h00};
  assign data_busy = (ser_reg == ST_READ) & (rs_reg == RS_DATA) & ~cread_reg;
  assign take_result = conv_result.valid & ~data_busy;
  assign cread_start = cread_reg & (ser_reg == ST_CMD) & ~rdy_n_reg & ~upd_pend_reg
                       & (sclk_fall | cs_fall);
  assign mode_wr = write_done & (rs_reg == RS_MODE);
  assign wr_md = wr_word[MD_HI:MD_LO];
  assign first_ch = next_enabled(chan_en, 3'h7);
  assign next_ch = next_enabled(chan_en, cur_ch_reg);
  assign seq_wrap = next_ch <= cur_ch_reg;

  function automatic logic [5:0] rd_len_sel(input logic [2:0] rs);
    return ((rs == RS_MODE) || (rs == RS_CONF)) ? LEN_WORD : LEN_BYTE;
  endfunction

  always_comb begin
    case (cmd_byte[RS_HI:RS_LO])
      RS_COMM: reg_word = {status_byte, 24'h000000};
      RS_MODE: reg_word = {mode_reg, 8'h00};
      RS_CONF: reg_word = {conf_reg, 8'h00};
      RS_DATA: reg_word = sta_en ? {data_reg, status_byte} : {data_reg, 8'h00};
      RS_ID: reg_word = {ID_VALUE, 24'h000000};
      default: reg_word = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial transfer engine

  always_ff @(posedge mclk) begin
    if (rst) begin
      ser_reg <= ST_CMD;
      bit_cnt_reg <= '0;
      len_reg <= LEN_BYTE;
      sh_in_reg <= '0;
      sh_out_reg <= '0;
      out_bit_reg <= 1'b1;
      pres_reg <= 1'b0;
      rs_reg <= RS_COMM;
      cread_reg <= 1'b0;
    end else if (cread_reg && (ser_reg == ST_READ) && upd_pend_reg) begin
      ser_reg <= ST_CMD;
      bit_cnt_reg <= '0;
      len_reg <= LEN_BYTE;
      sh_out_reg <= '0;
    end else if (cread_start) begin
      ser_reg <= ST_READ;
      bit_cnt_reg <= '0;
      len_reg <= sta_en ? LEN_WORD_STA : LEN_WORD;
      rs_reg <= RS_DATA;
      out_bit_reg <= cread_word[SHIFT_W-1];
      sh_out_reg <= {cread_word[SHIFT_W-2:0], 1'b0};
      pres_reg <= 1'b1;
    end else begin
      if (sclk_rise) begin
        sh_in_reg <= wr_word;
        bit_cnt_reg <= last_bit ? 6'h00 : bit_cnt_reg + 6'h01;
      end
      if (ser_reg == ST_READ && !pres_reg && cs_fall) begin
        out_bit_reg <= sh_out_reg[SHIFT_W-1];
        sh_out_reg <= {sh_out_reg[SHIFT_W-2:0], 1'b0};
        pres_reg <= 1'b1;
      end else if (ser_reg == ST_READ && sclk_fall) begin
        out_bit_reg <= sh_out_reg[SHIFT_W-1];
        sh_out_reg <= {sh_out_reg[SHIFT_W-2:0], 1'b0};
        pres_reg <= 1'b1;
      end
      // Exit command is watched while a continuous read runs
      if (ser_reg == ST_READ && cread_reg && sclk_rise && bit_cnt_reg == LEN_BYTE - 6'h01
          && cmd_byte == CMD_CREAD_EXIT) begin
        cread_reg <= 1'b0;
      end
      case (ser_reg)
        ST_CMD: begin
          if (cmd_done && !cread_reg) begin
            rs_reg <= cmd_byte[RS_HI:RS_LO];
            bit_cnt_reg <= '0;
            if (cmd_byte == CMD_CREAD_ENTER) begin
              cread_reg <= 1'b1;
              len_reg <= LEN_BYTE;
            end else if (cmd_byte[RW_BIT]) begin
              ser_reg <= ST_READ;
              len_reg <= (cmd_byte[RS_HI:RS_LO] == RS_DATA) ?
                         (sta_en ? LEN_WORD_STA : LEN_WORD) : rd_len_sel(cmd_byte[RS_HI:RS_LO]);
              sh_out_reg <= reg_word;
              pres_reg <= 1'b0;
            end else begin
              ser_reg <= ST_WRITE;
              len_reg <= rd_len_sel(cmd_byte[RS_HI:RS_LO]);
            end
          end
        end
        ST_WRITE: begin
          if (write_done) begin
            ser_reg <= ST_CMD;
            len_reg <= LEN_BYTE;
          end
        end
        ST_READ: begin
          if (read_done) begin
            ser_reg <= ST_CMD;
            len_reg <= LEN_BYTE;
          end
        end
        default: ser_reg <= ST_CMD;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result capture and ready flag

  always_ff @(posedge mclk) begin
    if (rst) begin
      data_reg <= '0;
      data_ch_reg <= '0;
      rdy_n_reg <= 1'b1;
      upd_pend_reg <= 1'b0;
      pend_word_reg <= '0;
      pend_ch_reg <= '0;
    end else begin
      if (upd_pend_reg) begin
        data_reg <= pend_word_reg;
        data_ch_reg <= pend_ch_reg;
        rdy_n_reg <= 1'b0;
        upd_pend_reg <= 1'b0;
      end else if (take_result) begin
        // Ready goes high a cycle ahead of the overwrite
        rdy_n_reg <= 1'b1;
        upd_pend_reg <= 1'b1;
        pend_word_reg <= conv_result.word;
        pend_ch_reg <= {1'b0, cur_ch_reg};
      end else if (read_done && rs_reg == RS_DATA) begin
        rdy_n_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode, configuration and channel sequencer

  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_reg <= MODE_RESET;
      conf_reg <= CONF_RESET;
      seq_reg <= SQ_START;
      cur_ch_reg <= first_ch_reset();
      osc_cnt_reg <= '0;
    end else begin
      if (write_done && rs_reg == RS_CONF) begin
        conf_reg <= wr_word;
      end
      if (mode_wr) begin
        mode_reg <= wr_word;
        cur_ch_reg <= first_ch;
        osc_cnt_reg <= '0;
        if ((wr_md == MD_SINGLE || wr_md == MD_CONT) && seq_reg == SQ_OFF) begin
          seq_reg <= SQ_WAKE;
        end else if (wr_md == MD_SINGLE || wr_md == MD_CONT) begin
          seq_reg <= SQ_START;
        end else begin
          seq_reg <= SQ_OFF;
        end
      end else begin
        case (seq_reg)
          SQ_OFF: seq_reg <= SQ_OFF;
          SQ_WAKE: begin
            // Oscillator start-up is counted, not measured
            osc_cnt_reg <= osc_cnt_reg + 1'b1;
            if (osc_cnt_reg == OSC_CNT_W'(OSC_START_CYCLES - 1)) begin
              seq_reg <= SQ_START;
            end
          end
          SQ_START: seq_reg <= (chan_en == 8'h00) ? SQ_START : SQ_WAIT;
          SQ_WAIT: begin
            if (conv_result.valid) begin
              if (md == MD_SINGLE && seq_wrap) begin
                seq_reg <= SQ_OFF;
                mode_reg[MD_HI:MD_LO] <= MD_PDOWN;
              end else begin
                cur_ch_reg <= next_ch;
                seq_reg <= SQ_START;
              end
            end
          end
          default: seq_reg <= SQ_OFF;
        endcase
      end
    end
  end

  function automatic logic [2:0] first_ch_reset();
    return next_enabled(CONF_RESET[EN_HI:EN_LO], 3'h7);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Shared output line

  always_ff @(posedge mclk) begin
    if (srst) begin
      dout_reg <= 1'b1;
      oe_reg <= 1'b0;
    end else begin
      dout_reg <= (ser_reg == ST_READ) ? out_bit_reg : rdy_n_reg;
      oe_reg <= selected;
    end
  end

  assign dout_rdy = dout_reg;
  assign dout_rdy_oe = oe_reg;
  assign conv_start = (seq_reg == SQ_START) && (chan_en != 8'h00);
  assign conv_channel = cur_ch_reg;
  assign conv_power_up = seq_reg != SQ_OFF;
  assign cread_active = cread_reg;
endmodule

// ---- bench/scp_port_properties.sv ----
// Pin-level checks of the serial command port
`timescale 1ns/1ps
module scp_port_properties #(
  parameter int OSC_START_CYCLES = 20
) (
  input wire logic mclk,
  input wire logic srst,
  input scp_pkg::scp_pins_s pins,
  input wire logic dout_rdy,
  input wire logic dout_rdy_oe,
  input scp_pkg::scp_result_s conv_result,
  input wire logic conv_start,
  input wire logic [2:0] conv_channel,
  input wire logic conv_power_up,
  input wire logic cread_active
);
  import scp_pkg::*;
  // Quiet means select low and clock high longer than half a bit
  logic [3:0] quiet_cnt;
  logic [5:0] ones_cnt;
  logic sclk_q;
  int pu_cnt;
  wire quiet = quiet_cnt == 4'hf;
  wire ones_hit = ones_cnt == 6'h28;
  always_ff @(posedge mclk) begin
    sclk_q <= pins.sclk;
    if (srst || pins.cs_n || !pins.sclk) quiet_cnt <= 4'h0;
    else if (!quiet) quiet_cnt <= quiet_cnt + 4'h1;
    if (srst || pins.cs_n) ones_cnt <= 6'h0;
    else if (pins.sclk && !sclk_q) ones_cnt <= pins.din ? ones_cnt + 6'h1 : 6'h0;
    if (srst) pu_cnt <= OSC_START_CYCLES;
    else if (!conv_power_up) pu_cnt <= 0;
    else if (pu_cnt < OSC_START_CYCLES) pu_cnt <= pu_cnt + 1;
  end
  default clocking dc @(posedge mclk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////
  oe_on_a: assert property (!pins.cs_n [*5] |-> dout_rdy_oe)
    else $error("line not driven while selected");
  oe_off_a: assert property (pins.cs_n [*5] |-> !dout_rdy_oe)
    else $error("line driven while deselected");
  rdy_high_a: assert property (conv_result.valid && quiet |-> ##2 dout_rdy ##1 !dout_rdy)
    else $error("ready not raised before update");
  rdy_cause_a: assert property ($fell(dout_rdy) && quiet |-> $past(conv_result.valid, 3))
    else $error("ready low without new result");
  start_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("start longer than one cycle");
  start_power_a: assert property (conv_start |-> conv_power_up)
    else $error("start while powered down");
  osc_wait_a: assert property (conv_start |-> pu_cnt >= OSC_START_CYCLES - 1)
    else $error("start before oscillator settled");
  ones_reset_a: assert property ($rose(ones_hit) |-> ##[1:8] (!cread_active && conv_power_up))
    else $error("ones run did not reset port");
  boot_cont_a: assert property ($fell(srst) |-> ##[0:4] conv_start)
    else $error("no conversion after reset");
  cover property (cread_active && $fell(dout_rdy));
  cover property ($fell(conv_power_up));
  cover property ($rose(ones_hit));
endmodule

bind scp_port scp_port_properties #(.OSC_START_CYCLES(OSC_START_CYCLES)) i_scp_port_properties (
  .mclk(mclk), .srst(srst), .pins(pins), .dout_rdy(dout_rdy), .dout_rdy_oe(dout_rdy_oe),
  .conv_result(conv_result), .conv_start(conv_start), .conv_channel(conv_channel),
  .conv_power_up(conv_power_up), .cread_active(cread_active));

// ---- bench/scp_conv_model.sv ----
// Converter model answering each start after a set delay
`timescale 1ns/1ps
module scp_conv_model (
  input wire logic mclk,
  input wire logic srst,
  input wire logic conv_start,
  input wire logic [2:0] conv_channel,
  input wire logic conv_power_up,
  input wire logic [11:0] delay,
  output scp_pkg::scp_result_s conv_result
);
  import scp_pkg::*;
  int cnt;
  logic [2:0] ch;
  // Word toggles when not valid so stale data never looks fresh
  always_ff @(posedge mclk) begin
    conv_result.valid <= 1'b0;
    conv_result.word <= ~conv_result.word;
    if (srst) begin
      cnt <= 0;
      conv_result.word <= 24'h000000;
    end else if (conv_start) begin
      cnt <= int'(delay);
      ch <= conv_channel;
    end else if (!conv_power_up) begin
      cnt <= 0;
    end else if (cnt == 1) begin
      conv_result.valid <= 1'b1;
      conv_result.word <= {5'h14, ch, 16'h5aa5};
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench of the serial command port
`timescale 1ns/1ps
module tb_top;
  import scp_pkg::*;
  localparam int OSC = 20;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  scp_pins_s pins = '{cs_n: 1'b1, sclk: 1'b1, din: 1'b0};
  logic [11:0] delay = 12'h5dc;
  logic dout_rdy, dout_rdy_oe, conv_start, conv_power_up, cread_active;
  logic [2:0] conv_channel;
  scp_result_s conv_result;
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;
  logic [39:0] r, s;
  initial forever #2 mclk = ~mclk;
  scp_port #(.OSC_START_CYCLES(OSC)) i_scp_port (.mclk(mclk), .srst(srst), .pins(pins),
    .dout_rdy(dout_rdy), .dout_rdy_oe(dout_rdy_oe), .conv_result(conv_result),
    .conv_start(conv_start), .conv_channel(conv_channel), .conv_power_up(conv_power_up),
    .cread_active(cread_active));
  scp_conv_model i_scp_conv_model (.mclk(mclk), .srst(srst), .conv_start(conv_start),
    .conv_channel(conv_channel), .conv_power_up(conv_power_up), .delay(delay),
    .conv_result(conv_result));
  ////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Mode 3 host: falls, drives data, rises and samples, 16 clocks a bit
  task automatic xfer(input int n, input logic [39:0] w, output logic [39:0] rd);
    rd = '0;
    for (int i = n - 1; i >= 0; i--) begin
      pins.sclk <= 1'b0;
      pins.din <= w[i];
      repeat (8) @(posedge mclk);
      pins.sclk <= 1'b1;
      rd = {rd[38:0], dout_rdy};
      repeat (8) @(posedge mclk);
    end
    pins.din <= 1'b0;
  endtask
  task automatic wait_rdy();
    int k;
    k = 0;
    while (dout_rdy !== 1'b0 && k < 4000) begin
      @(posedge mclk);
      k++;
    end
    check(32'(k < 4000), 32'h1);
    @(posedge mclk);
  endtask
  function automatic logic [31:0] word(input logic [2:0] ch);
    return {8'h00, 5'h14, ch, 16'h5aa5};
  endfunction
  ////////////////////////////////////////////////////////////////
  task automatic t_boot();
    check(32'(dout_rdy_oe), 32'h0);
    pins.cs_n <= 1'b0;
    wait_rdy();
    for (int i = 0; i < 2; i++) begin
      xfer(8, 40'h58, r);
      xfer(24, 40'h0, r);
      check(r[31:0], word(3'h0));
      repeat (4) @(posedge mclk);
      check(32'(dout_rdy), 32'h1);
    end
  endtask
  task automatic t_single();
    int k;
    xfer(8, 40'h08, r);
    xfer(24, 40'h400000, r);
    xfer(8, 40'h10, r);
    xfer(24, 40'h000500, r);
    xfer(8, 40'h58, r);
    xfer(24, 40'h0, r);
    xfer(8, 40'h08, r);
    xfer(24, 40'h300000, r);
    k = 0;
    while (!conv_start && k < 200) begin
      @(posedge mclk);
      k++;
    end
    // Transfer tail already spent up to 8 of the wake cycles
    check(32'(k >= OSC - 8 && k < 200), 32'h1);
    for (int c = 0; c < 4; c += 2) begin
      wait_rdy();
      xfer(8, 40'h58, r);
      xfer(32, 40'h0, r);
      check(r[31:0], {5'h14, 3'(c), 16'h5aa5, 5'h00, 3'(c)});
    end
    repeat (1600) @(posedge mclk);
    check(32'({conv_power_up, dout_rdy}), 32'h1);
  endtask
  task automatic t_cread();
    xfer(8, 40'h08, r);
    xfer(24, 40'h000000, r);
    xfer(8, 40'h5c, r);
    check(32'(cread_active), 32'h1);
    wait_rdy();
    xfer(24, 40'h0, r);
    wait_rdy();
    xfer(24, 40'h0, s);
    check(32'(r[18:16] ^ s[18:16]), 32'h2);
    wait_rdy();
    xfer(24, 40'h580000, r);
    check(32'(cread_active), 32'h0);
  endtask
  task automatic t_ones();
    xfer(8, 40'h5c, r);
    xfer(40, 40'hff_ffff_ffff, r);
    check(32'(cread_active), 32'h0);
    repeat (100) @(posedge mclk);
    wait_rdy();
    xfer(8, 40'h58, r);
    xfer(24, 40'h0, r);
    check(r[31:0], word(3'h0));
  endtask
  // Frame-sync host: select drops while clock is low, first rise takes the MSB
  task automatic t_frame();
    xfer(8, 40'h58, r);
    pins.cs_n <= 1'b1;
    pins.sclk <= 1'b0;
    repeat (8) @(posedge mclk);
    pins.cs_n <= 1'b0;
    r = '0;
    for (int i = 0; i < 24; i++) begin
      if (i > 0) pins.sclk <= 1'b0;
      repeat (8) @(posedge mclk);
      pins.sclk <= 1'b1;
      r = {r[38:0], dout_rdy};
      repeat (8) @(posedge mclk);
    end
    check(r[31:0], word(3'h0));
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    repeat (10) @(posedge mclk);
    t_boot();
    t_single();
    t_cread();
    t_ones();
    t_frame();
    wrap_up();
  end
endmodule
